// *** fspc_defines.vh ***
`ifndef FSPC_DEFINES_VH
`define FSPC_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FSPC_OFS_OPTION 12'h000
`define FSPC_OFS_CONFIG 12'h004
`define FSPC_OFS_PROTECT 12'h008
`define FSPC_OFS_STATUS 12'h00C
`define FSPC_OFS_KEY_LO 12'h010
`define FSPC_OFS_KEY_HI 12'h014
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define FSPC_OPT_BACKDOOR 7
`define FSPC_OPT_NORED 6
`define FSPC_OPT_USED_MASK 8'hC3
`define FSPC_CFG_KEYWR 5
`define FSPC_CFG_MASK 8'hE0
`define FSPC_PROT_DIS 0
`define FSPC_SEC_UNSECURE 2'h2
`define FSPC_ST_VIOL 0
`define FSPC_ST_UNSEC 1
`define FSPC_KEY_BASE 16'hFFB0
`define FSPC_KEY_BYTES 8
`define FSPC_CFG_RESET 8'h00
`define FSPC_PAGE_SHIFT 9
`endif

// *** fspc_top.v ***
`timescale 1ns/10ps
// Function
// - reset loads option mirror from nonvolatile byte
// - option bits five to two read zero
// - option mirror read only, writes ignored
// - backdoor disabled blocks key unlock
// - debug writes cannot load key bytes
// - matching eight byte key unsecures until reset
// - option bit six disables vector redirection
// - only security pattern 1:0 means unsecured
// - secure state blocks unsecured source accesses
// - key match or blank check unsecures
// - config bits 7-5 rw, 4-0 read zero
// - key range writes start flash command when off
// - key write enable captures key bytes
// - reset loads protect mirror from nonvolatile byte
// - protect mirror written only by debug
// - protect select gives unprotected end address
// - protected locations never erased or programmed
// - protect disable means nothing protected
// - clearing key enable triggers key compare
// - protected command ignored, sets sticky violation
`include "fspc_defines.vh"
module fspc_top #(
  parameter AW = 16
) (
  input wire CLK,
  input wire RSTN,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire [7:0] NV_OPTION_BYTE,
  input wire [7:0] NV_PROTECT_BYTE,
  input wire [63:0] STORED_BACKDOOR_KEY,
  input wire MEM_WR,
  input wire [AW-1:0] MEM_ADDR,
  input wire [7:0] MEM_WDATA,
  input wire MEM_DEBUG,
  input wire MEM_ACC,
  input wire MEM_SECURE_SRC,
  input wire CMD_LAUNCH,
  input wire CMD_ERASE_PROG,
  input wire [AW-1:0] CMD_ADDR,
  input wire BLANK_OK,
  output reg CMD_START,
  output reg CMD_ACCEPT,
  output reg ACCESS_BLOCK,
  output reg SECURE,
  output reg VECTOR_REDIRECT_DISABLE
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] option_mirror_r;
  reg [7:0] flash_config_reg_r;
  reg [7:0] protect_mirror_r;
  reg [7:0] key_buf_r [0:7];
  reg [7:0] key_seen_r;
  reg unsec_r;
  reg viol_r;
  reg loaded_r;
  reg ap_valid_r;
  reg ap_write_r;
  reg ap_debug_r;
  reg [11:0] ap_addr_r;
  wire [63:0] key_flat;
  wire key_wr_en;
  wire backdoor_enable;
  wire [1:0] security_field;
  wire key_hit;
  wire key_match;
  wire [AW-1:0] prot_start;
  wire cmd_protected;
  wire ap_take;
  wire cfg_wr;
  wire prot_wr;
  wire st_wr;
  wire key_close;
  wire secure_now;
  integer i;

  assign key_wr_en = flash_config_reg_r[`FSPC_CFG_KEYWR];
  assign backdoor_enable = option_mirror_r[`FSPC_OPT_BACKDOOR];
  // sticky unlock overrides stored field until reset
  assign security_field = unsec_r ? `FSPC_SEC_UNSECURE :
                          option_mirror_r[1:0];
  assign secure_now = (security_field != `FSPC_SEC_UNSECURE);
  assign key_hit = MEM_WR &&
    (MEM_ADDR[AW-1:3] == `FSPC_KEY_BASE >> 3);

  // one byte lane per key address, lowest address in the top byte
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_key_lane
      assign key_flat[63-8*g -: 8] = key_buf_r[g];
    end
  endgenerate
  // byte 0 at base address is key MSB, ascending order
  assign key_match = (key_seen_r == 8'hFF) &&
    (key_flat == STORED_BACKDOOR_KEY);

  // protected region: from protect_select boundary up to top
  assign prot_start = {protect_mirror_r[7:1], {(AW-7){1'b1}}} + 1'b1;
  assign cmd_protected = !protect_mirror_r[`FSPC_PROT_DIS] &&
    (CMD_ADDR >= prot_start) &&
    (protect_mirror_r[7:1] != 7'h7F);

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  assign ap_take = HSEL && HTRANS[1] && HREADY;
  assign cfg_wr = ap_valid_r && ap_write_r &&
    (ap_addr_r == `FSPC_OFS_CONFIG);
  assign prot_wr = ap_valid_r && ap_write_r &&
    (ap_addr_r == `FSPC_OFS_PROTECT);
  assign st_wr = ap_valid_r && ap_write_r &&
    (ap_addr_r == `FSPC_OFS_STATUS);
  assign key_close = cfg_wr && key_wr_en &&
    !HWDATA[`FSPC_CFG_KEYWR];

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_debug_r <= 1'b0;
      ap_addr_r <= 12'h000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      ap_valid_r <= ap_take;
      if (ap_take) begin
        ap_write_r <= HWRITE;
        ap_addr_r <= {HADDR[11:2], 2'b00};
        // hprot is absent; debug origin comes from the core port
        ap_debug_r <= MEM_DEBUG;
      end
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HRDATA <= 32'h00000000;
    end else if (ap_take && !HWRITE) begin
      case ({HADDR[11:2], 2'b00})
        `FSPC_OFS_OPTION:
          HRDATA <= {24'h000000,
                     option_mirror_r & `FSPC_OPT_USED_MASK};
        `FSPC_OFS_CONFIG:
          HRDATA <= {24'h000000,
                     flash_config_reg_r & `FSPC_CFG_MASK};
        `FSPC_OFS_PROTECT:
          HRDATA <= {24'h000000, protect_mirror_r};
        `FSPC_OFS_STATUS:
          HRDATA <= {30'h00000000, !secure_now, viol_r};
        `FSPC_OFS_KEY_LO:
          HRDATA <= key_flat[63:32];
        `FSPC_OFS_KEY_HI:
          HRDATA <= key_flat[31:0];
        default:
          HRDATA <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // mirrors loaded on first clock after reset release
  // ----------------------------------------
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      loaded_r <= 1'b0;
      option_mirror_r <= 8'h00;
      protect_mirror_r <= 8'h00;
      flash_config_reg_r <= `FSPC_CFG_RESET;
    end else begin
      loaded_r <= 1'b1;
      if (!loaded_r) begin
        option_mirror_r <= NV_OPTION_BYTE & `FSPC_OPT_USED_MASK;
        protect_mirror_r <= NV_PROTECT_BYTE;
      end else if (prot_wr && ap_debug_r) begin
        protect_mirror_r <= HWDATA[7:0];
      end
      if (cfg_wr) begin
        flash_config_reg_r <= HWDATA[7:0] & `FSPC_CFG_MASK;
      end
    end
  end

  // ----------------------------------------
  // backdoor key capture and compare
  // ----------------------------------------
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (i = 0; i < 8; i = i + 1) begin
        key_buf_r[i] <= 8'h00;
      end
      key_seen_r <= 8'h00;
      unsec_r <= 1'b0;
    end else begin
      if (key_hit && key_wr_en && !MEM_DEBUG && MEM_SECURE_SRC &&
          backdoor_enable) begin
        key_buf_r[MEM_ADDR[2:0]] <= MEM_WDATA;
        key_seen_r[MEM_ADDR[2:0]] <= 1'b1;
      end
      if (key_close) begin
        key_seen_r <= 8'h00;
        if (backdoor_enable && key_match) begin
          unsec_r <= 1'b1;
        end
        // mismatch keeps unsec_r as it was
      end
      if (BLANK_OK) begin
        unsec_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // command hook, violation flag, outputs
  // ----------------------------------------
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      viol_r <= 1'b0;
      CMD_START <= 1'b0;
      CMD_ACCEPT <= 1'b0;
      ACCESS_BLOCK <= 1'b0;
      SECURE <= 1'b1;
      VECTOR_REDIRECT_DISABLE <= 1'b0;
    end else begin
      CMD_START <= key_hit && !key_wr_en;
      CMD_ACCEPT <= CMD_LAUNCH && !(CMD_ERASE_PROG && cmd_protected);
      // set beats a same-cycle write-one clear
      if (CMD_LAUNCH && CMD_ERASE_PROG && cmd_protected) begin
        viol_r <= 1'b1;
      end else if (st_wr && HWDATA[`FSPC_ST_VIOL]) begin
        viol_r <= 1'b0;
      end
      ACCESS_BLOCK <= MEM_ACC && secure_now && !MEM_SECURE_SRC;
      SECURE <= secure_now;
      VECTOR_REDIRECT_DISABLE <= option_mirror_r[`FSPC_OPT_NORED];
    end
  end
endmodule // fspc_top

// *** fspc_top_assertions.sv ***
`timescale 1ns/10ps
module fspc_chk #(
  parameter AW = 16
) (
  input wire CLK,
  input wire RSTN,
  input wire [7:0] NV_OPTION_BYTE,
  input wire MEM_WR,
  input wire [AW-1:0] MEM_ADDR,
  input wire MEM_ACC,
  input wire CMD_LAUNCH,
  input wire CMD_ERASE_PROG,
  input wire BLANK_OK,
  input wire CMD_START,
  input wire CMD_ACCEPT,
  input wire ACCESS_BLOCK,
  input wire SECURE,
  input wire VECTOR_REDIRECT_DISABLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // mirrors load one edge after release, outputs settle two edges after release
  property p_vrd;
    $past(RSTN, 3) |-> VECTOR_REDIRECT_DISABLE == NV_OPTION_BYTE[6];
  endproperty
  a_vrd: assert property (p_vrd) else $error("redirect wrong");
  property p_rst;
    $rose(RSTN) |-> ##2 (SECURE == (NV_OPTION_BYTE[1:0] != 2'h2));
  endproperty
  a_rst: assert property (p_rst) else $error("secure wrong");
  property p_keep; $past(RSTN) |-> !$rose(SECURE); endproperty
  a_keep: assert property (p_keep) else $error("secure rose");
  property p_blank; BLANK_OK |-> ##[1:2] !SECURE; endproperty
  a_blank: assert property (p_blank) else $error("no unlock");
  property p_start;
    CMD_START |-> $past(MEM_WR) && $past(MEM_ADDR[15:3]) == 13'h1FF6;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_acc; CMD_ACCEPT |-> $past(CMD_LAUNCH); endproperty
  a_acc: assert property (p_acc) else $error("bad accept");
  property p_rdwr; CMD_LAUNCH && !CMD_ERASE_PROG |=> CMD_ACCEPT; endproperty
  a_rdwr: assert property (p_rdwr) else $error("refused");
  property p_blk; ACCESS_BLOCK |-> $past(MEM_ACC) && $past(SECURE); endproperty
  a_blk: assert property (p_blk) else $error("bad block");
endmodule // fspc_chk
bind fspc_top fspc_chk #(.AW(AW)) fspc_chk_i (.CLK(CLK), .RSTN(RSTN),
  .NV_OPTION_BYTE(NV_OPTION_BYTE), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR),
  .MEM_ACC(MEM_ACC), .CMD_LAUNCH(CMD_LAUNCH),
  .CMD_ERASE_PROG(CMD_ERASE_PROG), .BLANK_OK(BLANK_OK),
  .CMD_START(CMD_START), .CMD_ACCEPT(CMD_ACCEPT),
  .ACCESS_BLOCK(ACCESS_BLOCK), .SECURE(SECURE),
  .VECTOR_REDIRECT_DISABLE(VECTOR_REDIRECT_DISABLE));

// *** fspc_tb_top.sv ***
`timescale 1ns/10ps
module fspc_tb_top;
  localparam [63:0] KEY = 64'h0123456789ABCDEF;
  reg clk, rstn, hsel, hwrite, wr, dbg, acc, ssrc, lch, ep, blk;
  reg [1:0] htrans;
  reg [31:0] haddr, hwdata, rd;
  reg [7:0] nvo, nvp, wd;
  reg [15:0] addr;
  wire [31:0] hrdata;
  wire hrdy, cst, cac, abk, sec, vrd;
  integer failures = 0;
  integer num_checks = 0;
  integer i;
  // single slave: its ready is the bus ready
  fspc_top #(.AW(16)) fspc_top_i (.CLK(clk), .RSTN(rstn), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
    .HRESP(), .NV_OPTION_BYTE(nvo), .NV_PROTECT_BYTE(nvp),
    .STORED_BACKDOOR_KEY(KEY), .MEM_WR(wr), .MEM_ADDR(addr), .MEM_WDATA(wd),
    .MEM_DEBUG(dbg), .MEM_ACC(acc), .MEM_SECURE_SRC(ssrc), .CMD_LAUNCH(lch),
    .CMD_ERASE_PROG(ep), .CMD_ADDR(addr), .BLANK_OK(blk), .CMD_START(cst),
    .CMD_ACCEPT(cac), .ACCESS_BLOCK(abk), .SECURE(sec),
    .VECTOR_REDIRECT_DISABLE(vrd));
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      {hsel, htrans, hwrite, haddr} <= {3'h6, w, 24'h0, a};
      do @(posedge clk); while (hrdy !== 1'h1);
      {htrans, hwdata} <= {2'h0, 24'h0, d};
      do @(posedge clk); while (hrdy !== 1'h1);
      rd = hrdata;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      xfer(1'h0, a, 8'h0);
      chk(rd, {24'h0, e});
    end
  endtask
  // p: write, access, launch, blank-ok strobes
  task pls(input [3:0] p, input e, input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      {wr, acc, lch, blk, ep, addr, wd} <= {p, e, a, d};
      @(posedge clk);
      {wr, acc, lch, blk} <= 4'h0;
      #1;
    end
  endtask
  task key(input [63:0] k, input s);
    begin
      xfer(1'h1, 8'h4, 8'h20);
      for (i = 0; i < 8; i = i + 1) begin
        pls(4'h8, 1'h0, {13'h1FF6, i[2:0]}, k[63 - 8 * i -: 8]);
        chk(cst, 1'h0);
      end
      xfer(1'h1, 8'h4, 8'h0);
      rdc(8'hC, {6'h0, !s, 1'h0});
      chk(sec, s);
    end
  endtask
  task rst(input [7:0] o);
    begin
      {rstn, nvo} <= {1'h0, o};
      repeat (16) @(posedge clk);
      rstn <= 1'h1;
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #100000;
    failures = failures + 1;
    complete_run;
  end
  initial begin
    {rstn, hsel, hwrite, htrans, haddr, hwdata, addr, wd} = '0;
    {wr, dbg, acc, lch, ep, blk, ssrc, nvp} = {7'h0, 1'h1, 8'h01};
    rst(8'hFC);
    rdc(8'h0, 8'hC0);
    xfer(1'h1, 8'h0, 8'hFF);
    rdc(8'h0, 8'hC0);
    chk(vrd, 1'h1);
    xfer(1'h1, 8'h4, 8'hFF);
    rdc(8'h4, 8'hE0);
    xfer(1'h1, 8'h4, 8'h0);
    rdc(8'h8, 8'h01);
    xfer(1'h1, 8'h40, 8'hFF);
    rdc(8'h40, 8'h0);
    $display("test registers done");
    pls(4'h2, 1'h1, 16'hFFFF, 8'h0);
    chk(cac, 1'h1);
    xfer(1'h1, 8'h8, 8'h7E);
    rdc(8'h8, 8'h01);
    dbg <= 1'h1;
    xfer(1'h1, 8'h8, 8'h7E);
    dbg <= 1'h0;
    rdc(8'h8, 8'h7E);
    pls(4'h2, 1'h1, 16'h7FFF, 8'h0);
    chk(cac, 1'h1);
    pls(4'h2, 1'h1, 16'h8000, 8'h0);
    chk(cac, 1'h0);
    rdc(8'hC, 8'h1);
    xfer(1'h1, 8'hC, 8'h1);
    rdc(8'hC, 8'h0);
    $display("test protection done");
    pls(4'h8, 1'h0, 16'hFFB3, 8'h0);
    chk(cst, 1'h1);
    key(KEY ^ 64'h1, 1'h1);
    dbg <= 1'h1;
    key(KEY, 1'h1);
    {dbg, ssrc} <= 2'h0;
    pls(4'h4, 1'h0, 16'h0, 8'h0);
    chk(abk, 1'h1);
    ssrc <= 1'h1;
    key(KEY, 1'h0);
    $display("test key done");
    for (i = 0; i < 4; i = i + 1) begin
      rst({6'h10, i[1:0]});
      chk(sec, i != 2);
    end
    key(KEY, 1'h1);
    pls(4'h1, 1'h0, 16'h0, 8'h0);
    rdc(8'hC, 8'h2);
    $display("test security done");
    complete_run;
  end
endmodule // fspc_tb_top
